// ==== core/tcg_pkg.sv ====
package tcg_pkg;
  // ==========================================================
  // Divider ratios from the master oscillator
  // ==========================================================
  localparam int TCG_DIV_BIT = 10;      // 2.048 MHz bus bit clock
  localparam int TCG_DIV_FRAME = 2560;  // 8 kHz frame clock
  localparam int TCG_DIV_SUB = 128;     // 160 kHz clock
  localparam int TCG_CNT_W = 12;        // Wide enough for the frame divider

  // ==========================================================
  // Tone and slot geometry
  // ==========================================================
  localparam int TCG_NUM_TONES = 24;
  localparam int TCG_NUM_SLOTS = 256;
  localparam int TCG_SLOT_W = 8;
  localparam int TCG_TONE_W = 5;
  localparam int TCG_SAMPLE_W = 8;
  localparam logic [4:0] TCG_NO_TONE = 5'h1F;
  localparam logic [4:0] TCG_LAST_TONE = 5'h17;
  localparam logic [7:0] TCG_LAST_SLOT = 8'hFF;
  // Slot at which the generator counter starts each frame
  localparam logic [7:0] TCG_GEN_START_SLOT = 8'h00;
  localparam int TCG_FIFO_DEPTH = 32;

  // Generator request sequencer
  typedef enum logic [0:0] {
    TCG_GEN_IDLE,
    TCG_GEN_RUN
  } tcg_gen_state_type;
endpackage

// ==== core/tcg_fifo.sv ====
`timescale 1ns/1ps
module tcg_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // ==========================================================
  // Flags
  // ==========================================================
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r];

  // Storage has no reset; only the pointers and count need a defined value
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap naturally when depth is a power of two
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== core/tcg_shared_slot_memory.sv ====
`timescale 1ns/1ps
module tcg_shared_slot_memory #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic a_wr_en,
  input wire logic [$clog2(DEPTH)-1:0] a_addr,
  input wire logic [WIDTH-1:0] a_wr_data,
  output logic [WIDTH-1:0] a_rd_data,
  input wire logic [$clog2(DEPTH)-1:0] b_addr,
  output logic [WIDTH-1:0] b_rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================
  // Port A writes and reads back, port B reads only
  // ==========================================================
  always_ff @(posedge clk) begin
    if (a_wr_en) begin
      mem[a_addr] <= a_wr_data;
    end
    a_rd_data <= mem[a_addr];
  end

  // Registered read; a same-cycle write on A shows next access
  always_ff @(posedge clk) begin
    b_rd_data <= mem[b_addr];
  end
endmodule

// ==== core/tcg_clock_tone_gen.sv ====
// Contract
// - Divide master clock by 10, 2560, 128 for three bus clocks.
// - Clocks run freely from power-up; no processor control exists.
// - Drive the three derived clocks onto the bus for everyone.
// - Derived timing keeps generator and slot counters frame aligned.
// - Dual-ported tone store holds 24 tones, one address each.
// - Generator counter requests one sample per tone every frame.
// - Generator counter locked to frame with fixed lead offset.
// - Slot table is dual-ported, 256 entries, one per slot.
// - Slot counter walks table; selected tone driven each slot.
`timescale 1ns/1ps
module tcg_clock_tone_gen
  import tcg_pkg::*;
#(
  parameter int DIV_BIT = TCG_DIV_BIT,
  parameter int DIV_FRAME = TCG_DIV_FRAME,
  parameter int DIV_SUB = TCG_DIV_SUB,
  parameter int SAMPLE_W = TCG_SAMPLE_W,
  parameter int FIFO_DEPTH = TCG_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  // Bus clocks
  output logic bus_bit_clk_r,
  output logic bus_frame_clk_r,
  output logic bus_sub_clk_r,
  // Sample requests to the tone synthesiser
  output logic gen_req_r,
  output logic [TCG_TONE_W-1:0] gen_req_tone_r,
  // Samples back from the synthesiser
  input wire logic smp_valid,
  output logic smp_ready_r,
  input wire logic [TCG_TONE_W-1:0] smp_tone,
  input wire logic [SAMPLE_W-1:0] smp_data,
  // Processor port onto the slot table
  input wire logic up_wr_en,
  input wire logic [TCG_SLOT_W-1:0] up_addr,
  input wire logic [TCG_TONE_W-1:0] up_wr_data,
  output logic [TCG_TONE_W-1:0] up_rd_data_r,
  // Tone lane of the bus
  output logic [SAMPLE_W-1:0] tdm_tone_out_r,
  output logic tdm_tone_oe_b_r,
  output logic [TCG_SLOT_W-1:0] slot_num_r
);
  localparam int FW = TCG_TONE_W + SAMPLE_W;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Step a divider counter, wrapping at ratio-1
  function automatic logic [TCG_CNT_W-1:0] div_step(
    input logic [TCG_CNT_W-1:0] cnt,
    input int ratio
  );
    if (cnt == TCG_CNT_W'(ratio - 1)) begin
      div_step = '0;
    end else begin
      div_step = cnt + 1'b1;
    end
  endfunction

  // Square wave: high for the first half of each period
  function automatic logic div_level(
    input logic [TCG_CNT_W-1:0] cnt,
    input int ratio
  );
    div_level = (cnt < TCG_CNT_W'(ratio / 2));
  endfunction

  // ==========================================================
  // Clock divider
  // ==========================================================
  logic [TCG_CNT_W-1:0] bit_cnt_r;
  logic [TCG_CNT_W-1:0] frame_cnt_r;
  logic [TCG_CNT_W-1:0] sub_cnt_r;
  logic slot_tick;
  logic frame_tick;

  // One pulse per slot and per frame; both wrap on the same edge
  assign slot_tick = (bit_cnt_r == TCG_CNT_W'(DIV_BIT - 1));
  assign frame_tick = (frame_cnt_r == TCG_CNT_W'(DIV_FRAME - 1));

  // Reset only seeds the counters; there is no other control input
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bit_cnt_r <= '0;
      frame_cnt_r <= '0;
      sub_cnt_r <= '0;
    end else begin
      bit_cnt_r <= div_step(bit_cnt_r, DIV_BIT);
      frame_cnt_r <= div_step(frame_cnt_r, DIV_FRAME);
      sub_cnt_r <= div_step(sub_cnt_r, DIV_SUB);
    end
  end

  // Registered clock outputs toward the bus drivers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_bit_clk_r <= 1'b0;
      bus_frame_clk_r <= 1'b0;
      bus_sub_clk_r <= 1'b0;
    end else begin
      bus_bit_clk_r <= div_level(bit_cnt_r, DIV_BIT);
      bus_frame_clk_r <= div_level(frame_cnt_r, DIV_FRAME);
      bus_sub_clk_r <= div_level(sub_cnt_r, DIV_SUB);
    end
  end

  // ==========================================================
  // Slot counter
  // ==========================================================
  logic [TCG_SLOT_W-1:0] slot_cnt_r;

  // Reloaded by the frame tick so a glitch cannot leave it skewed
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slot_cnt_r <= '0;
    end else if (frame_tick) begin
      slot_cnt_r <= '0;
    end else if (slot_tick) begin
      slot_cnt_r <= slot_cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // Tone generator counter
  // ==========================================================
  tcg_gen_state_type gen_state_r;
  logic [TCG_TONE_W-1:0] gen_idx_r;
  logic gen_start;

  // Start at a fixed slot so samples land a frame ahead of use
  assign gen_start = slot_tick && (slot_cnt_r == TCG_GEN_START_SLOT);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gen_state_r <= TCG_GEN_IDLE;
      gen_idx_r <= '0;
    end else begin
      case (gen_state_r)
        TCG_GEN_IDLE: begin
          if (gen_start) begin
            gen_state_r <= TCG_GEN_RUN;
            gen_idx_r <= '0;
          end
        end
        TCG_GEN_RUN: begin
          if (slot_tick) begin
            if (gen_idx_r == TCG_LAST_TONE) begin
              gen_state_r <= TCG_GEN_IDLE;
            end else begin
              gen_idx_r <= gen_idx_r + 1'b1;
            end
          end
        end
        default: begin
          gen_state_r <= TCG_GEN_IDLE;
        end
      endcase
    end
  end

  // One request pulse per tone, on the slot boundary
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gen_req_r <= 1'b0;
      gen_req_tone_r <= '0;
    end else begin
      gen_req_r <= (gen_state_r == TCG_GEN_RUN) && slot_tick;
      gen_req_tone_r <= gen_idx_r;
    end
  end

  // ==========================================================
  // Sample FIFO into the tone store
  // ==========================================================
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [FW-1:0] fifo_out_data;
  logic tone_wr_en;
  logic [TCG_TONE_W-1:0] tone_rd_idx_r;
  logic [SAMPLE_W-1:0] tone_rd_data;

  // Drain one sample per slot; a burst from the synthesiser backs up
  assign fifo_pop = fifo_out_valid && slot_tick;
  // Out-of-range indices are dropped so nothing aliases a real tone
  assign tone_wr_en = fifo_pop &&
    (fifo_out_data[FW-1 -: TCG_TONE_W] <= TCG_LAST_TONE);

  tcg_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(smp_valid && smp_ready_r),
    .in_ready(fifo_in_ready),
    .in_data({smp_tone, smp_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Ready is registered, so it lags fullness by a cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      smp_ready_r <= 1'b0;
    end else begin
      smp_ready_r <= fifo_in_ready && !(smp_valid && smp_ready_r);
    end
  end

  // Tone store: synthesiser side writes, bus side reads
  tcg_shared_slot_memory #(
    .WIDTH(SAMPLE_W),
    .DEPTH(TCG_NUM_TONES)
  ) u_tone_mem (
    .clk(clk),
    .a_wr_en(tone_wr_en),
    .a_addr(fifo_out_data[FW-1 -: TCG_TONE_W]),
    .a_wr_data(fifo_out_data[SAMPLE_W-1:0]),
    .a_rd_data(),
    .b_addr(tone_rd_idx_r),
    .b_rd_data(tone_rd_data)
  );

  // ==========================================================
  // Slot table
  // ==========================================================
  logic [TCG_TONE_W-1:0] up_rd_data;
  logic [TCG_TONE_W-1:0] slot_entry;

  tcg_shared_slot_memory #(
    .WIDTH(TCG_TONE_W),
    .DEPTH(TCG_NUM_SLOTS)
  ) u_slot_table (
    .clk(clk),
    .a_wr_en(up_wr_en),
    .a_addr(up_addr),
    .a_wr_data(up_wr_data),
    .a_rd_data(up_rd_data),
    .b_addr(slot_cnt_r),
    .b_rd_data(slot_entry)
  );

  // Readback for the processor, two cycles after the address
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      up_rd_data_r <= TCG_NO_TONE;
    end else begin
      up_rd_data_r <= up_rd_data;
    end
  end

  // ==========================================================
  // Bus output pipeline
  // ==========================================================
  // The table entry for the new slot settles a cycle after the counter
  // moves, so it is latched at stage 1; the store answers at stage 3
  logic [3:0] stage_r;
  logic drive_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage_r <= '0;
      tone_rd_idx_r <= '0;
      drive_r <= 1'b0;
    end else begin
      stage_r <= {stage_r[2:0], slot_tick};
      if (stage_r[1]) begin
        tone_rd_idx_r <= slot_entry;
        drive_r <= (slot_entry <= TCG_LAST_TONE);
      end
    end
  end

  // Pins change once per slot, a fixed few cycles into it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tdm_tone_out_r <= '0;
      tdm_tone_oe_b_r <= 1'b1;
      slot_num_r <= '0;
    end else if (stage_r[3]) begin
      tdm_tone_oe_b_r <= !drive_r;
      tdm_tone_out_r <= drive_r ? tone_rd_data : '0;
      slot_num_r <= slot_cnt_r;
    end
  end
endmodule

// ==== tb/tcg_monitor.sv ====
`timescale 1ns/1ps
module tcg_monitor
  import tcg_pkg::*;
#(
  parameter int DIV_FRAME = TCG_DIV_FRAME,
  parameter int DIV_SUB = TCG_DIV_SUB,
  parameter int SAMPLE_W = TCG_SAMPLE_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bus_bit_clk_r,
  input wire logic bus_frame_clk_r,
  input wire logic bus_sub_clk_r,
  input wire logic gen_req_r,
  input wire logic [TCG_TONE_W-1:0] gen_req_tone_r,
  input wire logic smp_valid,
  input wire logic smp_ready_r,
  input wire logic [SAMPLE_W-1:0] tdm_tone_out_r,
  input wire logic tdm_tone_oe_b_r,
  input wire logic [TCG_SLOT_W-1:0] slot_num_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  int frame_len_r;
  int sub_len_r;
  int stall_n_r;
  logic frame_seen_r;

  // ==========================================================
  // Frame length counter
  // ==========================================================
  // Too long for a repetition, so count cycles since the last rise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      frame_len_r <= 0;
      frame_seen_r <= 1'b0;
    end else if ($rose(bus_frame_clk_r)) begin
      frame_len_r <= 0;
      frame_seen_r <= 1'b1;
    end else begin
      frame_len_r <= frame_len_r + 1;
    end
  end

  // Sub clock period, counted the same way as the frame
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sub_len_r <= 0;
    end else if ($rose(bus_sub_clk_r)) begin
      sub_len_r <= 0;
    end else begin
      sub_len_r <= sub_len_r + 1;
    end
  end

  // Cycles an offer has waited; only a full FIFO makes it wait long
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stall_n_r <= 0;
    end else if (smp_valid && !smp_ready_r) begin
      stall_n_r <= stall_n_r + 1;
    end else begin
      stall_n_r <= 0;
    end
  end

  // ==========================================================
  // Properties
  // ==========================================================
  bit_clk_shape_a: assert property ($rose(bus_bit_clk_r) |->
    bus_bit_clk_r[*5] ##1 !bus_bit_clk_r[*5] ##1 bus_bit_clk_r)
    else $error("bit clock not a ten cycle square wave");
  frame_period_a: assert property (
    $rose(bus_frame_clk_r) && frame_seen_r |-> frame_len_r == DIV_FRAME - 1)
    else $error("frame clock period wrong");
  frame_duty_a: assert property (
    $fell(bus_frame_clk_r) && frame_seen_r |-> frame_len_r == DIV_FRAME/2 - 1)
    else $error("frame clock high time wrong");
  sub_period_a: assert property (
    $rose(bus_sub_clk_r) && frame_seen_r |-> sub_len_r == DIV_SUB - 1)
    else $error("sub clock period wrong");
  clock_align_a: assert property ($rose(bus_frame_clk_r) |->
    $rose(bus_bit_clk_r) && $rose(bus_sub_clk_r))
    else $error("bus clocks not aligned at frame start");
  gen_lead_a: assert property ($rose(bus_frame_clk_r) |->
    ##19 gen_req_r && gen_req_tone_r == 5'h00)
    else $error("first tone request not at fixed frame offset");
  gen_order_a: assert property (
    gen_req_r && gen_req_tone_r < TCG_LAST_TONE |-> ##10 gen_req_r &&
    gen_req_tone_r == $past(gen_req_tone_r, 10) + 5'h01)
    else $error("tone requests not in order ten cycles apart");
  slot_step_a: assert property ($changed(slot_num_r) |->
    slot_num_r == $past(slot_num_r) + 8'h01)
    else $error("slot number skipped");
  lane_idle_a: assert property (
    tdm_tone_oe_b_r |-> tdm_tone_out_r == '0)
    else $error("tone lane carries data while released");
  fifo_full_c: cover property (stall_n_r == 6);
  no_tone_c: cover property ($changed(slot_num_r) && tdm_tone_oe_b_r);
  frame_c: cover property ($rose(bus_frame_clk_r) && frame_seen_r);
endmodule

// ==== tb/tcg_synth_model.sv ====
`timescale 1ns/1ps
module tcg_synth_model
  import tcg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic gen_req_r,
  input wire logic [TCG_TONE_W-1:0] gen_req_tone_r,
  input wire logic smp_ready_r,
  input wire logic [7:0] base,
  input wire logic [3:0] delay,
  input wire logic burst,
  output logic smp_valid,
  output logic [TCG_TONE_W-1:0] smp_tone,
  output logic [TCG_SAMPLE_W-1:0] smp_data
);
  logic [4:0] pend[$];
  int wait_n;
  int junk_n;
  // Requests queue up; one offer stands until taken, then a pause
  always @(posedge clk) begin
    if (gen_req_r)
      pend.push_back(gen_req_tone_r);
    if (burst)
      junk_n = 100;
    if (!rst_b) begin
      pend.delete();
      junk_n = 0;
      wait_n = 0;
      smp_valid <= 1'b0;
      smp_tone <= 5'h00;
      smp_data <= 8'h00;
    end else if (smp_valid && smp_ready_r) begin
      // Released lines flip so a stale value never looks fresh
      smp_valid <= 1'b0;
      smp_tone <= ~smp_tone;
      smp_data <= ~smp_data;
      wait_n = delay;
    end else if (!smp_valid && wait_n > 0) begin
      wait_n--;
    end else if (!smp_valid && junk_n > 0) begin
      // Out-of-range index floods the FIFO but is dropped at drain
      junk_n--;
      smp_valid <= 1'b1;
      smp_tone <= 5'h1E;
      smp_data <= 8'($urandom());
    end else if (!smp_valid && pend.size() > 0) begin
      smp_valid <= 1'b1;
      smp_tone <= pend[0];
      smp_data <= base ^ {3'h0, pend.pop_front()};
    end
  end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import tcg_pkg::*;
  logic clk, rst_b, burst, up_wr_en, bit_clk, frame_clk, sub_clk;
  logic gen_req, smp_valid, smp_ready, oe_b;
  logic [4:0] req_tone, smp_tone, up_wr_data, up_rd_data;
  logic [7:0] smp_data, up_addr, tone_out, slot_num, base;
  logic [3:0] delay;
  logic [4:0] tbl[256];
  int fails, checks, low_run, full_seen;

  tcg_clock_tone_gen DUT (
    .clk(clk), .rst_b(rst_b), .bus_bit_clk_r(bit_clk),
    .bus_frame_clk_r(frame_clk), .bus_sub_clk_r(sub_clk),
    .gen_req_r(gen_req), .gen_req_tone_r(req_tone),
    .smp_valid(smp_valid), .smp_ready_r(smp_ready), .smp_tone(smp_tone),
    .smp_data(smp_data), .up_wr_en(up_wr_en), .up_addr(up_addr),
    .up_wr_data(up_wr_data), .up_rd_data_r(up_rd_data),
    .tdm_tone_out_r(tone_out), .tdm_tone_oe_b_r(oe_b),
    .slot_num_r(slot_num));
  tcg_synth_model u_synth (
    .clk(clk), .rst_b(rst_b), .gen_req_r(gen_req),
    .gen_req_tone_r(req_tone), .smp_ready_r(smp_ready), .base(base),
    .delay(delay), .burst(burst), .smp_valid(smp_valid),
    .smp_tone(smp_tone), .smp_data(smp_data));

  // ==========================================================
  // Clock, watchdog and full-FIFO watch
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Roughly twice the expected run
  initial begin
    #400000;
    fails++;
    summarize();
  end
  // Ready comes back two cycles after a take unless the FIFO is full
  always @(posedge clk) begin
    if (smp_valid === 1'b1 && smp_ready === 1'b0)
      low_run <= low_run + 1;
    else
      low_run <= 0;
    if (low_run > 4)
      full_seen <= 1;
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Back-to-back writes; the first entries hit the last tone and the index just past it
  task automatic fill();
    logic [4:0] v;
    for (int i = 0; i < 256; i++) begin
      v = (i < 2) ? 5'h17 + 5'(i) : 5'($urandom_range(31));
      tbl[i] = v;
      up_wr_en <= 1'b1;
      up_addr <= 8'(i);
      up_wr_data <= v;
      @(posedge clk);
    end
    up_wr_en <= 1'b0;
  endtask
  task automatic readback();
    for (int i = 0; i < 258; i++) begin
      @(posedge clk);
      up_addr <= 8'(i);
      #1;
      if (i >= 2)
        check(32'(up_rd_data), 32'(tbl[i-2]));
    end
  endtask
  // Follows the slot counter and compares the lane with the table model
  task automatic watch(input int n, input bit cmp);
    logic [7:0] s;
    logic [8:0] e;
    int k;
    for (int i = 0; i < n; i++) begin
      s = slot_num + 8'h01;
      k = 0;
      while (slot_num !== s && k < 12) begin
        @(posedge clk);
        #1;
        k++;
      end
      e = (tbl[s] <= TCG_LAST_TONE) ? {1'b0, base ^ {3'h0, tbl[s]}} : 9'h100;
      if (cmp)
        check(32'(slot_num), 32'(s));
      if (cmp)
        check(32'({oe_b, tone_out}), 32'(e));
    end
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rst_b = 1'b0;
    burst = 1'b0;
    up_wr_en = 1'b0;
    up_addr = 8'h00;
    up_wr_data = 5'h00;
    base = 8'h00;
    delay = 4'h0;
    void'($urandom(32'hC54B9373));
    repeat (6) @(posedge clk);
    #1;
    check({bit_clk, frame_clk, sub_clk, gen_req, smp_ready, oe_b, tone_out,
      up_rd_data}, 32'h0201F);
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    fill();
    readback();
    // Fast partner, then a flood that fills the FIFO, then a slow partner
    for (int r = 0; r < 3; r++) begin
      @(posedge clk);
      base <= 8'($urandom());
      delay <= (r == 2) ? 4'h5 : 4'h0;
      burst <= (r == 1);
      @(posedge clk);
      burst <= 1'b0;
      if (r == 2)
        fill();
      #1;
      watch(512, 0);
      watch(256, 1);
    end
    check(32'(full_seen), 32'h1);
    summarize();
  end
endmodule

bind tcg_clock_tone_gen tcg_monitor #(
  .DIV_FRAME(DIV_FRAME), .DIV_SUB(DIV_SUB), .SAMPLE_W(SAMPLE_W)
) u_mon (
  .clk(clk), .rst_b(rst_b), .bus_bit_clk_r(bus_bit_clk_r),
  .bus_frame_clk_r(bus_frame_clk_r), .bus_sub_clk_r(bus_sub_clk_r),
  .gen_req_r(gen_req_r), .gen_req_tone_r(gen_req_tone_r),
  .smp_valid(smp_valid), .smp_ready_r(smp_ready_r),
  .tdm_tone_out_r(tdm_tone_out_r), .tdm_tone_oe_b_r(tdm_tone_oe_b_r),
  .slot_num_r(slot_num_r));
